// ### cal_pkg.sv
// package: opcodes, flag positions, cycle counts and carriers for the alu
package cal_pkg;
	// operation codes from the decoder
	typedef enum logic [4:0] {
		CAL_OP_ADD        = 5'h00,
		CAL_OP_ADC        = 5'h01,
		CAL_OP_ADD_IMM_W  = 5'h02,
		CAL_OP_SUB        = 5'h03,
		CAL_OP_SUB_IMM    = 5'h04,
		CAL_OP_SUB_C      = 5'h05,
		CAL_OP_SUB_C_IMM  = 5'h06,
		CAL_OP_SUB_IMM_W  = 5'h07,
		CAL_OP_AND        = 5'h08,
		CAL_OP_AND_IMM    = 5'h09,
		CAL_OP_OR         = 5'h0a,
		CAL_OP_OR_IMM     = 5'h0b,
		CAL_OP_XOR        = 5'h0c,
		CAL_OP_SET_BITS   = 5'h0d,
		CAL_OP_CLR_BITS   = 5'h0e,
		CAL_OP_TEST       = 5'h0f,
		CAL_OP_IJUMP      = 5'h10,
		CAL_OP_INDIRECT_CALL      = 5'h11
	} cal_op_e;

	// status register bit positions
	localparam int CAL_F_C = 0;
	localparam int CAL_F_Z = 1;
	localparam int CAL_F_N = 2;
	localparam int CAL_F_V = 3;
	localparam int CAL_F_S = 4;
	localparam int CAL_F_H = 5;

	// byte, word and counter constants
	localparam logic [7:0] CAL_ALL_ONES = 8'hff;
	localparam logic [7:0] CAL_ZERO8    = 8'h00;
	localparam logic [7:0] CAL_SREG_RST = 8'h00;
	localparam logic [15:0] CAL_PC_RST  = 16'h0000;
	localparam logic [15:0] CAL_PC_STEP = 16'h0001;
	localparam logic [1:0] CAL_CNT_ZERO = 2'h0;
	localparam logic [1:0] CAL_CYC_WORD = 2'h2;
	localparam logic [1:0] CAL_CYC_JMP  = 2'h2;
	localparam logic [1:0] CAL_CYC_CALL = 2'h3;
	localparam logic [1:0] CAL_CNT_ONE  = 2'h1;

	// one request from the decoder and register file
	typedef struct packed {
		cal_op_e    op;
		logic [7:0] dst;
		logic [7:0] src;
		logic [7:0] imm;
		logic [7:0] dst_hi;
		logic [15:0] ptr;
		logic [15:0] pc;
	} cal_req_s;

	// result of one operation
	typedef struct packed {
		logic       wr_lo;
		logic       wr_hi;
		logic [7:0] res_lo;
		logic [7:0] res_hi;
		logic       pc_load;
		logic [15:0] pc_val;
		logic       push;
		logic [15:0] ret_addr;
	} cal_res_s;

	// sequencer states
	typedef enum logic [2:0] {
		CAL_ST_IDLE = 3'b001,
		CAL_ST_BUSY = 3'b010,
		CAL_ST_DONE = 3'b100
	} cal_st_e;
endpackage

// ### cal_byte_alu.sv
// combinational byte arithmetic and logic unit with flags
`timescale 1ns/1ns
module cal_byte_alu
	import cal_pkg::*;
(
	input  wire cal_op_e    op,
	input  wire logic [7:0] a,
	input  wire logic [7:0] b,
	input  wire logic [7:0] sreg_in,
	output logic      [7:0] res,
	output logic      [7:0] sreg_out
);
	logic [8:0] sum;     // with carry out
	logic [4:0] low;     // nibble for half carry
	logic       cin;     // carry in
	logic       logic_op;

	// compute result and flags
	always_comb begin
		sum = 9'h000;
		low = 5'h00;
		logic_op = 1'b0;
		res = a;
		sreg_out = sreg_in;
		cin = sreg_in[CAL_F_C];
		case (op)
			// additions
			CAL_OP_ADD, CAL_OP_ADC: begin
				if (op == CAL_OP_ADD) begin
					cin = 1'b0;
				end
				sum = {1'b0, a} + {1'b0, b} + {8'h00, cin};
				low = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
				res = sum[7:0];
				sreg_out[CAL_F_C] = sum[8];
				sreg_out[CAL_F_H] = low[4];
				sreg_out[CAL_F_V] = (a[7] == b[7]) && (res[7] != a[7]);
			end
			// subtractions, carry variants borrow too
			CAL_OP_SUB, CAL_OP_SUB_IMM, CAL_OP_SUB_C,
			CAL_OP_SUB_C_IMM: begin
				if (op == CAL_OP_SUB || op == CAL_OP_SUB_IMM) begin
					cin = 1'b0;
				end
				sum = {1'b0, a} - {1'b0, b} - {8'h00, cin};
				low = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, cin};
				res = sum[7:0];
				sreg_out[CAL_F_C] = sum[8];
				sreg_out[CAL_F_H] = low[4];
				sreg_out[CAL_F_V] = (a[7] != b[7]) && (res[7] != a[7]);
			end
			// logic family: and, xor, or, clear bits, test
			CAL_OP_AND, CAL_OP_AND_IMM: begin
				res = a & b;
				logic_op = 1'b1;
			end
			CAL_OP_XOR: begin
				res = a ^ b;
				logic_op = 1'b1;
			end
			CAL_OP_OR, CAL_OP_OR_IMM, CAL_OP_SET_BITS: begin
				res = a | b;
				logic_op = 1'b1;
			end
			CAL_OP_CLR_BITS: begin
				res = a & (CAL_ALL_ONES - b);
				logic_op = 1'b1;
			end
			CAL_OP_TEST: begin
				res = a & a;
				logic_op = 1'b1;
			end
			default: begin
				res = a;
			end
		endcase
		if (logic_op) begin
			sreg_out[CAL_F_V] = 1'b0;
		end
		// z and n for all byte ops
		if (op != CAL_OP_IJUMP && op != CAL_OP_INDIRECT_CALL &&
				op != CAL_OP_ADD_IMM_W && op != CAL_OP_SUB_IMM_W) begin
			sreg_out[CAL_F_Z] = (res == CAL_ZERO8);
			sreg_out[CAL_F_N] = res[7];
		end
	end
endmodule

// ### cal_word_unit.sv
// combinational 16-bit add and subtract immediate on a register pair
`timescale 1ns/1ns
module cal_word_unit
	import cal_pkg::*;
(
	input  wire logic        sub,
	input  wire logic [15:0] pair,
	input  wire logic [7:0]  imm,
	input  wire logic [7:0]  sreg_in,
	output logic      [15:0] res,
	output logic      [7:0]  sreg_out
);
	logic [16:0] ext; // with carry or borrow out

	// word arithmetic and its flags
	always_comb begin
		sreg_out = sreg_in;
		if (sub) begin
			ext = {1'b0, pair} - {9'h000, imm};
			sreg_out[CAL_F_V] = pair[15] & ~ext[15];
		end else begin
			ext = {1'b0, pair} + {9'h000, imm};
			sreg_out[CAL_F_V] = ~pair[15] & ext[15];
		end
		res = ext[15:0];
		sreg_out[CAL_F_C] = ext[16];
		sreg_out[CAL_F_Z] = (res == 16'h0000);
		sreg_out[CAL_F_N] = res[15];
		sreg_out[CAL_F_S] = res[15] ^ sreg_out[CAL_F_V];
	end
endmodule

// ### cal_alu_top.sv
// execution datapath top: sequencing, flags, register and pc writeback
`timescale 1ns/1ns
module cal_alu_top
	import cal_pkg::*;
(
	input  wire logic       core_clk,    // 250 mhz core clock
	input  wire logic       rst_n,       // async low reset
	input  wire logic       start,       // decoder issues one operation
	input  wire cal_req_s   req,         // operands and operation
	output logic            busy,        // operation in progress
	output logic            done,        // one-cycle completion pulse
	output cal_res_s        result,      // writeback and pc update
	output logic [7:0]      sreg         // status register
);
	// all module state except the reset synchroniser
	typedef struct packed {
		cal_st_e    st;
		logic [1:0] cnt;
		logic       busy;
		logic       done;
		cal_res_s   res;
		cal_res_s   pend;
		logic [7:0] sreg;
		logic [7:0] pend_sreg;
	} cal_state_s;

	cal_state_s  s_r;         // registered state
	cal_state_s  s_nxt;       // next state
	logic [1:0]  rst_sync_r;  // reset release synchroniser
	logic        rst_int_n;   // synchronised reset
	logic [7:0]  b_op;        // second byte operand
	logic [7:0]  byte_res;    // byte result
	logic [7:0]  byte_sreg;   // byte flags
	logic [15:0] word_res;    // word result
	logic [7:0]  word_sreg;   // word flags
	logic        is_sub_w;    // word subtract select

	// release reset through two flip-flops
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_sync_r <= 2'h0;
		end else begin
			rst_sync_r <= {rst_sync_r[0], 1'b1};
		end
	end
	assign rst_int_n = rst_sync_r[1];

	// choose register or immediate source
	always_comb begin
		case (req.op)
			CAL_OP_SUB_IMM, CAL_OP_SUB_C_IMM, CAL_OP_AND_IMM,
			CAL_OP_OR_IMM, CAL_OP_SET_BITS, CAL_OP_CLR_BITS: begin
				b_op = req.imm;
			end
			default: begin
				b_op = req.src;
			end
		endcase
	end
	assign is_sub_w = (req.op == CAL_OP_SUB_IMM_W);

	// byte unit
	cal_byte_alu cal_byte_alu_inst (
		.op       (req.op),
		.a        (req.dst),
		.b        (b_op),
		.sreg_in  (s_r.sreg),
		.res      (byte_res),
		.sreg_out (byte_sreg)
	);

	// word unit
	cal_word_unit cal_word_unit_inst (
		.sub      (is_sub_w),
		.pair     ({req.dst_hi, req.dst}),
		.imm      (req.imm),
		.sreg_in  (s_r.sreg),
		.res      (word_res),
		.sreg_out (word_sreg)
	);

	// sequencer and writeback
	always_comb begin
		s_nxt = s_r;
		s_nxt.done = 1'b0;
		s_nxt.res = '0;
		case (s_r.st)
			// accept a new operation
			CAL_ST_IDLE: begin
				if (start) begin
					s_nxt.pend = '0;
					s_nxt.pend_sreg = s_r.sreg;
					case (req.op)
						CAL_OP_ADD_IMM_W, CAL_OP_SUB_IMM_W: begin
							s_nxt.pend.wr_lo = 1'b1;
							s_nxt.pend.wr_hi = 1'b1;
							s_nxt.pend.res_lo = word_res[7:0];
							s_nxt.pend.res_hi = word_res[15:8];
							s_nxt.pend_sreg = word_sreg;
							s_nxt.cnt = CAL_CYC_WORD - CAL_CNT_ONE;
						end
						CAL_OP_IJUMP: begin
							s_nxt.pend.pc_load = 1'b1;
							s_nxt.pend.pc_val = req.ptr;
							s_nxt.cnt = CAL_CYC_JMP - CAL_CNT_ONE;
						end
						CAL_OP_INDIRECT_CALL: begin
							s_nxt.pend.pc_load = 1'b1;
							s_nxt.pend.pc_val = req.ptr;
							s_nxt.pend.push = 1'b1;
							s_nxt.pend.ret_addr = req.pc + CAL_PC_STEP;
							s_nxt.cnt = CAL_CYC_CALL - CAL_CNT_ONE;
						end
						CAL_OP_TEST: begin
							s_nxt.sreg = byte_sreg;
							s_nxt.done = 1'b1;
						end
						default: begin
							s_nxt.res.wr_lo = 1'b1;
							s_nxt.res.res_lo = byte_res;
							s_nxt.sreg = byte_sreg;
							s_nxt.done = 1'b1;
						end
					endcase
					if (req.op == CAL_OP_ADD_IMM_W ||
							req.op == CAL_OP_SUB_IMM_W ||
							req.op == CAL_OP_IJUMP ||
							req.op == CAL_OP_INDIRECT_CALL) begin
						s_nxt.st = CAL_ST_BUSY;
						s_nxt.busy = 1'b1;
					end
				end
			end
			// count down the extra cycles
			CAL_ST_BUSY: begin
				if (s_r.cnt == CAL_CNT_ONE) begin
					s_nxt.res = s_r.pend;
					s_nxt.sreg = s_r.pend_sreg;
					s_nxt.done = 1'b1;
					s_nxt.busy = 1'b0;
					s_nxt.st = CAL_ST_IDLE;
					s_nxt.cnt = CAL_CNT_ZERO;
				end else begin
					s_nxt.cnt = s_r.cnt - CAL_CNT_ONE;
				end
			end
			default: begin
				s_nxt.st = CAL_ST_IDLE;
				s_nxt.busy = 1'b0;
			end
		endcase
	end

	// state register
	always_ff @(posedge core_clk or negedge rst_int_n) begin
		if (!rst_int_n) begin
			s_r <= '{st: CAL_ST_IDLE, cnt: CAL_CNT_ZERO, busy: 1'b0,
				done: 1'b0, res: '0, pend: '0, sreg: CAL_SREG_RST,
				pend_sreg: CAL_SREG_RST};
		end else begin
			s_r <= s_nxt;
		end
	end

	// outputs straight from flip-flops
	assign busy = s_r.busy;
	assign done = s_r.done;
	assign result = s_r.res;
	assign sreg = s_r.sreg;
endmodule

// ### cal_alu_monitor.sv
// checker watching the ports of the alu datapath top
`timescale 1ns/1ns
module cal_alu_monitor
	import cal_pkg::*;
(
	input wire logic       core_clk,
	input wire logic       rst_n,
	input wire logic       start,
	input wire cal_req_s   req,
	input wire logic       busy,
	input wire logic       done,
	input wire cal_res_s   result,
	input wire logic [7:0] sreg
);
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);
	logic take;	// operation accepted at this edge
	logic wide;	// word operation on a register pair
	assign take = start && !busy;
	assign wide = req.op inside {CAL_OP_ADD_IMM_W, CAL_OP_SUB_IMM_W};
	one_cycle_a: assert property (
		take && req.op < CAL_OP_IJUMP && !wide |=> done)
		else $error("single cycle op did not finish in one cycle");
	word_time_a: assert property (
		take && wide |=> busy && !done ##1 done && !busy)
		else $error("word op did not take two cycles");
	jump_time_a: assert property (
		take && req.op == CAL_OP_IJUMP |=> !done ##1 done
		&& result.pc_load && result.pc_val == $past(req.ptr, 2))
		else $error("jump did not load pointer after two cycles");
	call_time_a: assert property (
		take && req.op == CAL_OP_INDIRECT_CALL |=> !done [*2] ##1 done
		&& result.push && result.pc_val == $past(req.ptr, 3)
		&& result.ret_addr == $past(req.pc, 3) + CAL_PC_STEP)
		else $error("call did not save and load after three cycles");
	flow_flags_a: assert property (
		take && req.op >= CAL_OP_IJUMP |=> $stable(sreg) [*2])
		else $error("jump or call changed flags");
	logic_v_a: assert property (
		take && req.op inside {[CAL_OP_AND:CAL_OP_TEST]} |=>
		!sreg[CAL_F_V] && sreg[CAL_F_C] == $past(sreg[CAL_F_C]))
		else $error("logic op left overflow set or touched carry");
	zero_neg_a: assert property (
		done && result.wr_lo && !result.wr_hi |->
		sreg[CAL_F_Z] == (result.res_lo == 8'h00)
		&& sreg[CAL_F_N] == result.res_lo[7])
		else $error("zero or negative flag wrong for byte result");
	word_sign_a: assert property (
		done && result.wr_hi |->
		sreg[CAL_F_S] == (sreg[CAL_F_N] ^ sreg[CAL_F_V])
		&& sreg[CAL_F_Z] == ({result.res_hi, result.res_lo} == 16'h0000))
		else $error("sign or zero flag wrong for word result");
	quiet_res_a: assert property (!done |-> result == '0)
		else $error("result not zero outside done cycle");
endmodule
bind cal_alu_top cal_alu_monitor cal_alu_monitor_inst(.core_clk(core_clk),
	.rst_n(rst_n), .start(start), .req(req), .busy(busy), .done(done),
	.result(result), .sreg(sreg));

// ### cal_regfile_model.sv
// register file side: takes writeback and pc updates from the datapath
`timescale 1ns/1ns
module cal_regfile_model
	import cal_pkg::*;
(
	input  wire logic      core_clk,
	input  wire logic      rst_n,
	input  wire logic      done,
	input  wire cal_res_s  result,
	output logic    [15:0] pair_q,
	output logic    [15:0] pc_q,
	output logic    [15:0] ret_q
);
	// strobes pick the bytes; only the done cycle counts
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			pair_q <= '0;
			pc_q <= '0;
			ret_q <= '0;
		end else if (done) begin
			if (result.wr_lo) pair_q[7:0] <= result.res_lo;
			if (result.wr_hi) pair_q[15:8] <= result.res_hi;
			if (result.pc_load) pc_q <= result.pc_val;
			if (result.push) ret_q <= result.ret_addr;
		end
	end
endmodule

// ### cal_alu_top_bench.sv
// self-checking bench for the alu datapath
`timescale 1ns/1ns
module cal_alu_top_bench
	import cal_pkg::*;
;
	logic        core_clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        start = 1'b0;
	cal_req_s    req = '0;
	logic        busy;
	logic        done;
	cal_res_s    result;
	logic [7:0]  sreg;
	logic [15:0] pair_q;
	logic [15:0] pc_q;
	logic [15:0] ret_q;
	int          fails = 0;
	int          n_checks = 0;
	always #2 core_clk = ~core_clk;
	cal_alu_top cal_alu_top_inst(.core_clk(core_clk), .rst_n(rst_n),
		.start(start), .req(req), .busy(busy), .done(done),
		.result(result), .sreg(sreg));
	cal_regfile_model cal_regfile_model_inst(.core_clk(core_clk),
		.rst_n(rst_n), .done(done), .result(result), .pair_q(pair_q),
		.pc_q(pc_q), .ret_q(ret_q));
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
		n_checks++;
		if (got !== exp) begin
			$display("unexpected %s expected %h seen %h", what, exp, got);
			fails++;
		end
	endtask
	// issue one op, wait for done, compare cycles, result and flags
	task automatic run(cal_op_e o, logic [7:0] d, s, i, h,
		logic [15:0] eres, logic [7:0] es, int ecyc = 1,
		logic [15:0] p = '0);
		int n;
		n = 0;
		@(negedge core_clk);
		start = 1'b1;
		req = '{o, d, s, i, h, p, 16'h0100};
		while (n < 8) begin
			@(negedge core_clk);
			start = 1'b0;
			n++;
			if (done === 1'b1) break;
			chk("busy", 16'h0001, {15'h0000, busy});
		end
		if (done !== 1'b1) begin
			$display("unexpected done expected 1 seen %b", done);
			fails++;
			give_verdict();
		end
		chk("cycles", 16'(ecyc), 16'(n));
		chk("busy", 16'h0000, {15'h0000, busy});
		if (o < CAL_OP_TEST) begin
			chk("result", eres, {result.wr_hi ? result.res_hi : 8'h00,
				result.wr_lo ? result.res_lo : 8'h00});
		end else begin
			// test, jump and call write no register
			chk("strobes", 16'h0000,
				{14'h0000, result.wr_hi, result.wr_lo});
		end
		chk("flags", {8'h00, es}, {8'h00, sreg});
	endtask
	task automatic t_arith();
		run(CAL_OP_ADD, 8'h7f, 8'h01, '0, '0, 16'h0080, 8'h2c);
		run(CAL_OP_SUB, 8'h00, 8'h01, '0, '0, 16'h00ff, 8'h25);
		run(CAL_OP_ADC, 8'h01, 8'h01, '0, '0, 16'h0003, 8'h00);
		run(CAL_OP_SUB_C, 8'h80, 8'h01, '0, '0, 16'h007f, 8'h28);
		run(CAL_OP_SUB_IMM, 8'h05, '0, 8'h05, '0, '0, 8'h02);
		run(CAL_OP_SUB, 8'h00, 8'h01, '0, '0, 16'h00ff, 8'h25);
		run(CAL_OP_SUB_C_IMM, 8'h10, '0, 8'h05, '0, 16'h000a, 8'h20);
	endtask
	task automatic t_word();
		run(CAL_OP_SUB_IMM_W, '0, '0, 8'h01, '0, 16'hffff, 8'h35, 2);
		run(CAL_OP_ADD_IMM_W, 8'hff, '0, 8'h01, 8'h7f, 16'h8000, 8'h2c, 2);
		@(negedge core_clk);
		chk("pair", 16'h8000, pair_q);
	endtask
	task automatic t_logic();
		run(CAL_OP_AND, 8'h0f, 8'hf0, '0, '0, '0, 8'h22);
		run(CAL_OP_AND_IMM, 8'hf0, '0, 8'h80, '0, 16'h0080, 8'h24);
		run(CAL_OP_OR, 8'h01, 8'h80, '0, '0, 16'h0081, 8'h24);
		run(CAL_OP_OR_IMM, '0, '0, '0, '0, '0, 8'h22);
		run(CAL_OP_XOR, 8'haa, 8'haa, '0, '0, '0, 8'h22);
		run(CAL_OP_SET_BITS, 8'h01, '0, 8'h80, '0, 16'h0081, 8'h24);
		run(CAL_OP_CLR_BITS, 8'hff, '0, 8'h0f, '0, 16'h00f0, 8'h24);
		run(CAL_OP_TEST, '0, '0, '0, '0, '0, 8'h22);
	endtask
	task automatic t_flow();
		run(CAL_OP_IJUMP, '0, '0, '0, '0, '0, 8'h22, 2, 16'h1234);
		@(negedge core_clk);
		chk("pc", 16'h1234, pc_q);
		run(CAL_OP_INDIRECT_CALL, '0, '0, '0, '0, '0, 8'h22, 3, 16'habcd);
		@(negedge core_clk);
		chk("pc", 16'habcd, pc_q);
		chk("return", 16'h0101, ret_q);
	endtask
	// a start held high while busy must be ignored
	task automatic t_refuse();
		@(negedge core_clk);
		start = 1'b1;
		req = '{CAL_OP_ADD_IMM_W, 8'h01, '0, 8'h01, 8'h00, '0, '0};
		@(negedge core_clk);
		req = '{CAL_OP_ADD, 8'h10, 8'h10, '0, '0, '0, '0};
		@(negedge core_clk);
		start = 1'b0;
		chk("done", 16'h0001, {15'h0000, done});
		chk("result", 16'h0002, {result.res_hi, result.res_lo});
		chk("flags", 16'h0020, {8'h00, sreg});
		@(negedge core_clk);
		chk("done", 16'h0000, {15'h0000, done});
	endtask
	// reset, then the scenarios in turn
	initial begin
		repeat (10) @(negedge core_clk);
		rst_n = 1'b1;
		repeat (3) @(negedge core_clk);
		t_arith();
		t_word();
		t_logic();
		t_flow();
		t_refuse();
		give_verdict();
	end
endmodule
